// [core/tlp_defines.vh]
`ifndef TLP_DEFINES_VH
`define TLP_DEFINES_VH
`define TLP_ADDR_LIMIT 8'h7A
`define TLP_ADDR_PULSES 8'h7B
`define TLP_ADDR_TSTAT 8'h79
`define TLP_ADDR_ISTAT2 8'h42
`define TLP_ADDR_MASK2 8'h75
`define TLP_ISTAT2_TMR_BIT 5
`define TLP_MASK2_F4_BIT 5
`define TLP_LIMIT_RESET 8'h00
`define TLP_PULSES_RESET 8'h55
`define TLP_FIRST_FAN_PULSE_COUNT_LSB 0
`define TLP_SECOND_FAN_PULSE_COUNT_LSB 2
`define TLP_THIRD_FAN_PULSE_COUNT_LSB 4
`define TLP_FOURTH_FAN_PULSE_COUNT_LSB 6
`define TLP_STEP_US 22760
`define TLP_CLK_NS 10
`define TLP_STEP_CYC ((`TLP_STEP_US * 1000) / `TLP_CLK_NS)
`endif

// [core/tlp_tach_meas.v]
`timescale 1ns/1ps
`include "tlp_defines.vh"
module tlp_tach_meas #(
  parameter CW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire tach_pulse,
  input wire [1:0] pulse_sel,
  output reg [CW-1:0] period,
  output reg done
);
  // =====================================================================
  // Measurement of one fan: counts clocks over the selected pulse count.
  reg [2:0] pulses;
  reg [2:0] target;
  reg [CW-1:0] cnt;
  reg running;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulses <= 3'h0;
      target <= 3'h2;
      cnt <= {CW{1'b0}};
      running <= 1'b0;
      period <= {CW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!running) begin
        if (tach_pulse) begin
          running <= 1'b1;
          pulses <= 3'h0;
          cnt <= {{(CW-1){1'b0}}, 1'b1};
          target <= {1'b0, pulse_sel} + 3'h1; // [RULE_15]
        end
      end else begin
        cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        if (tach_pulse) begin
          if (pulses + 3'h1 == target) begin
            running <= 1'b0; // [RULE_15]
            period <= cnt;
            done <= 1'b1;
          end else begin
            pulses <= pulses + 3'h1;
          end
        end
      end
    end
  end
endmodule // tlp_tach_meas

// [core/tlp_thermal_alarm_pin_limit.v]
`timescale 1ns/1ps
`include "tlp_defines.vh"
// Behaviour
// [RULE_01] Limit is 8 bits, 22.76 ms per count.
// [RULE_02] Limit spans 45.52 ms to 5.82 s; the code flags up to 5.80 s, and a limit of 0xFF never flags.
// [RULE_03] Exceeding limit sets status bit 5 at 0x42.
// [RULE_04] Zero limit flags immediately on assertion.
// [RULE_05] Limit register read/write, resets to zero.
// [RULE_06] Bits 1:0 select fan one pulses.
// [RULE_07] Bits 3:2 select fan two pulses.
// [RULE_08] Bits 5:4 select fan three pulses.
// [RULE_09] Bits 7:6 select fan four pulses.
// [RULE_10] Pulse register read/write, resets to 0x55.
// [RULE_11] Time assertion; upper bits zero until 45.52 ms.
// [RULE_12] Bit zero sets on assertion, clears on read.
// [RULE_13] Fourth fan mask suppresses timer alert.
// [RULE_14] Flag set within one step after limit.
// [RULE_15] Measurement ends at pulses chosen at start.
module tlp_thermal_alarm_pin_limit #(
  parameter STEP_CYC = `TLP_STEP_CYC,
  parameter CW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire thermal_alarm_pin_n,
  input wire fourth_speed_input_is_alarm,
  input wire [3:0] tach_in,
  output reg [7:0] reg_rdata,
  output reg fourth_fan_or_timer_flag,
  output reg alert_n,
  output reg [4*CW-1:0] fan_period,
  output reg [3:0] fan_done
);
  // =====================================================================
  // Input synchronisers.
  reg [1:0] alarm_sync;
  reg [3:0] tach_s1;
  reg [3:0] tach_s2;
  reg [3:0] tach_s3;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alarm_sync <= 2'h0;
      tach_s1 <= 4'h0;
      tach_s2 <= 4'h0;
      tach_s3 <= 4'h0;
    end else begin
      alarm_sync <= {alarm_sync[0], ~thermal_alarm_pin_n};
      tach_s1 <= tach_in;
      tach_s2 <= tach_s1;
      tach_s3 <= tach_s2;
    end
  end
  wire alarm = alarm_sync[1];
  wire [3:0] tach_rise = tach_s2 & ~tach_s3;

  // =====================================================================
  // Registers.
  reg [7:0] assertion_time_limit_field;
  reg [7:0] fan_pulse_count_select;
  reg fourth_fan_mask;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      assertion_time_limit_field <= `TLP_LIMIT_RESET; // [RULE_05]
      fan_pulse_count_select <= `TLP_PULSES_RESET; // [RULE_10]
      fourth_fan_mask <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `TLP_ADDR_LIMIT) begin
        assertion_time_limit_field <= reg_wdata; // [RULE_01]
      end else if (reg_addr == `TLP_ADDR_PULSES) begin
        fan_pulse_count_select <= reg_wdata;
      end else if (reg_addr == `TLP_ADDR_MASK2) begin
        fourth_fan_mask <= reg_wdata[`TLP_MASK2_F4_BIT];
      end
    end
  end

  // =====================================================================
  // Assertion timer.
  reg [31:0] step_cnt;
  reg [7:0] assertion_time_count;
  reg assertion_seen_bit;
  reg [7:0] run_steps;
  reg alarm_d;
  wire rd_tstat = reg_rd && (reg_addr == `TLP_ADDR_TSTAT);
  wire rd_istat = reg_rd && (reg_addr == `TLP_ADDR_ISTAT2);
  wire step_tick = alarm && (step_cnt == STEP_CYC - 1);
  wire rise = alarm && !alarm_d;
  wire [7:0] next_steps = (run_steps == 8'hFF) ? 8'hFF : run_steps + 8'h01;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= 32'h0;
      run_steps <= 8'h00;
      alarm_d <= 1'b0;
      assertion_time_count <= 8'h00;
      assertion_seen_bit <= 1'b0;
    end else begin
      alarm_d <= alarm;
      if (!alarm || step_tick) begin
        step_cnt <= 32'h0;
      end else begin
        step_cnt <= step_cnt + 32'h1;
      end
      if (rise) begin
        run_steps <= 8'h00;
      end else if (step_tick) begin
        run_steps <= next_steps; // [RULE_11]
      end
      if (step_tick && next_steps >= 8'h02) begin
        assertion_time_count <= next_steps; // [RULE_11]
      end else if (rd_tstat) begin
        assertion_time_count <= 8'h00;
      end
      if (rise || (step_tick && next_steps >= 8'h02)) begin
        assertion_seen_bit <= 1'b1; // [RULE_12]
      end else if (rd_tstat) begin
        assertion_seen_bit <= 1'b0; // [RULE_12]
      end
    end
  end
  wire [7:0] tstat_view = (assertion_time_count >= 8'h02) ?
                          {assertion_time_count[7:1], 1'b1} : {7'h00, assertion_seen_bit};

  // =====================================================================
  // Limit compare and status flag; set wins over clear on read.
  wire limit_hit = (assertion_time_limit_field == 8'h00) ? rise : // [RULE_04]
                   (step_tick && next_steps > assertion_time_limit_field); // [RULE_14] [RULE_02]
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fourth_fan_or_timer_flag <= 1'b0;
      alert_n <= 1'b1;
    end else begin
      if (limit_hit && fourth_speed_input_is_alarm) begin
        fourth_fan_or_timer_flag <= 1'b1; // [RULE_03]
      end else if (rd_istat) begin
        fourth_fan_or_timer_flag <= 1'b0;
      end
      alert_n <= ~(fourth_fan_or_timer_flag && !fourth_fan_mask); // [RULE_13]
    end
  end

  // =====================================================================
  // Read data.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `TLP_ADDR_LIMIT) begin
        reg_rdata <= assertion_time_limit_field;
      end else if (reg_addr == `TLP_ADDR_PULSES) begin
        reg_rdata <= fan_pulse_count_select;
      end else if (reg_addr == `TLP_ADDR_TSTAT) begin
        reg_rdata <= tstat_view;
      end else if (reg_addr == `TLP_ADDR_ISTAT2) begin
        reg_rdata <= {2'h0, fourth_fan_or_timer_flag, 5'h00};
      end else if (reg_addr == `TLP_ADDR_MASK2) begin
        reg_rdata <= {2'h0, fourth_fan_mask, 5'h00};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // =====================================================================
  // Fan measurements.
  wire [4*CW-1:0] per_w;
  wire [3:0] done_w;
  wire [7:0] sel = fan_pulse_count_select; // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_fan
      tlp_tach_meas #(.CW(CW)) u_meas (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tach_pulse(tach_rise[i]),
        .pulse_sel(sel[2*i+1:2*i]),
        .period(per_w[CW*i+CW-1:CW*i]),
        .done(done_w[i])
      );
    end
  endgenerate
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fan_period <= {4*CW{1'b0}};
      fan_done <= 4'h0;
    end else begin
      fan_period <= per_w;
      fan_done <= done_w;
    end
  end
endmodule // tlp_thermal_alarm_pin_limit

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
// ==========
// Register, tachometer and alarm timer tests.
module tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic alarm_on = 1'b0, tach_on = 1'b0, alarm_sel = 1'b1, pin_n, flag, alert_n;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] tach_in, fan_done;
  logic [63:0] fan_period;
  int n_errors = 0, comparisons = 0, k, c, f;
  always #5 clk_sys = ~clk_sys;
  tlp_thermal_alarm_pin_limit #(.STEP_CYC(10), .CW(16)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .thermal_alarm_pin_n(pin_n), .fourth_speed_input_is_alarm(alarm_sel), .tach_in(tach_in),
    .reg_rdata(reg_rdata), .fourth_fan_or_timer_flag(flag), .alert_n(alert_n),
    .fan_period(fan_period), .fan_done(fan_done));
  tlp_partner u_part (.clk_sys(clk_sys), .alarm_on(alarm_on), .tach_on(tach_on),
    .thermal_alarm_pin_n(pin_n), .tach_in(tach_in));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wdone(input int i);
    for (k = 0; k < 3000; k++) begin
      @(posedge clk_sys);
      #1 if (fan_done[i] === 1'b1) break;
    end
    if (k == 3000) `CHK(1'b0, 1'b1)
  endtask
  task automatic finish_test;
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h7A, 8'h00);
    rd(8'h7B, 8'h55);
    rd(8'h80, 8'h00);
    @(posedge clk_sys) tach_on <= 1'b1;
    for (c = 0; c < 4; c++) begin
      wr(8'h7B, {c[1:0] + 2'd3, c[1:0] + 2'd2, c[1:0] + 2'd1, c[1:0]});
      for (f = 0; f < 4; f++) begin
        wdone(f);
        wdone(f);
        `CHK(fan_period[16*f +: 16], 16'((c + f) % 4 + 1 << (f + 3)))
      end
    end
    rd(8'h7B, 8'h93);
    wr(8'h7A, 8'h00);
    @(posedge clk_sys) alarm_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 `CHK(flag, 1'b1)
    `CHK(alert_n, 1'b0)
    rd(8'h42, 8'h20);
    wr(8'h75, 8'h20);
    alarm_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(8'h42, 8'h00);
    @(posedge clk_sys) alarm_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 `CHK(flag, 1'b1)
    `CHK(alert_n, 1'b1)
    rd(8'h79, 8'h01);
    @(posedge clk_sys) alarm_on <= 1'b0;
    wr(8'h7A, 8'h03);
    rd(8'h7A, 8'h03);
    rd(8'h42, 8'h20);
    @(posedge clk_sys) alarm_on <= 1'b1;
    repeat (36) @(posedge clk_sys);
    #1 `CHK(flag, 1'b0)
    repeat (14) @(posedge clk_sys);
    #1 `CHK(flag, 1'b1)
    rd(8'h79, 8'h05);
    @(posedge clk_sys) alarm_on <= 1'b0;
    alarm_sel <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(8'h42, 8'h20);
    wr(8'h7A, 8'h00);
    @(posedge clk_sys) alarm_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 `CHK(flag, 1'b0)
    finish_test;
  end
endmodule // tb_top

// [dv/tlp_checker.sv]
`timescale 1ns/1ps
// ==========
// Checks on read data, status flag, alert and fan results.
module tlp_checker #(
  parameter CW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire fourth_fan_or_timer_flag,
  input wire alert_n,
  input wire [4*CW-1:0] fan_period,
  input wire [3:0] fan_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h7B |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_FLAG_CLR: assert property ($fell(fourth_fan_or_timer_flag) |->
    $past(reg_rd && reg_addr == 8'h42))
    else $error("flag cleared without status read");
  AST_FLAG_HOLD: assert property ($past(fourth_fan_or_timer_flag) && !$past(reg_rd) |->
    fourth_fan_or_timer_flag)
    else $error("flag dropped");
  AST_ALERT_LOW: assert property (!alert_n |-> $past(fourth_fan_or_timer_flag))
    else $error("alert without flag");
  AST_ALERT_HIGH: assert property (!fourth_fan_or_timer_flag |=> alert_n)
    else $error("alert low with flag clear");
  AST_DONE: assert property (fan_done[3] |=> !fan_done[3])
    else $error("done longer than one cycle");
  AST_PERIOD: assert property ($changed(fan_period[CW-1:0]) |-> fan_done[0])
    else $error("period changed without done");
endmodule // tlp_checker
bind tlp_thermal_alarm_pin_limit tlp_checker #(.CW(CW)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .alert_n(alert_n),
  .fourth_fan_or_timer_flag(fourth_fan_or_timer_flag), .fan_period(fan_period),
  .fan_done(fan_done));

// [dv/tlp_partner.sv]
`timescale 1ns/1ps
// ==========
// Alarm source and four fan tachometers; tach i has a period of 2^(i+3) clocks.
module tlp_partner (
  input wire logic clk_sys,
  input wire logic alarm_on,
  input wire logic tach_on,
  output logic thermal_alarm_pin_n,
  output logic [3:0] tach_in
);
  logic [7:0] cnt = 8'h00;
  always @(posedge clk_sys) begin
    cnt <= cnt + 8'h01;
  end
  assign thermal_alarm_pin_n = ~alarm_on;
  assign tach_in = tach_on ? cnt[5:2] : 4'h0;
endmodule // tlp_partner
